// >>> design/gpio_pkg.sv
// Package: register map, port widths and reset values for the five-port GPIO
package gpio_pkg;
	localparam int unsigned PORT_COUNT = 5;
	localparam int unsigned PORT_WIDTH = 8;
	localparam logic [7:0] PORT_MASK_A = 8'hFF;
	localparam logic [7:0] PORT_MASK_B = 8'hFF;
	localparam logic [7:0] PORT_MASK_C = 8'hFF;
	localparam logic [7:0] PORT_MASK_D = 8'h7F;
	localparam logic [7:0] PORT_MASK_E = 8'hFF;
	localparam logic [7:0] PORT_A_INPUT_ONLY = 8'h01;
	localparam logic [7:0] KEYPAD_IRQ_UNIT_TWO_SELECT_MASK = 8'h0F;
	localparam logic [11:0] OFFSET_DATA = 12'h000;
	localparam logic [11:0] OFFSET_DIR = 12'h004;
	localparam logic [11:0] OFFSET_PULLUP = 12'h008;
	localparam logic [11:0] PORT_STRIDE = 12'h010;
	localparam logic [11:0] OFFSET_KEYPAD_IRQ_UNIT_ONE_SEL = 12'h050;
	localparam logic [11:0] OFFSET_KEYPAD_IRQ_UNIT_TWO_SEL = 12'h054;
	localparam logic [11:0] OFFSET_SYS_CTRL = 12'h058;
	localparam int unsigned CTRL_DEBUG_RELEASE = 0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int unsigned ADDR_WIDTH = 12;
endpackage : gpio_pkg

// >>> design/five_port_gpio.sv
// Five-port GPIO with peripheral pin sharing and an AXI4-Lite register slave
// Functional notes
// - Per pin data, direction, input-only pullup bits
// - Idle peripheral returns pin to GPIO control
// - 39 pins: four 8-bit ports, one 7-bit
// - Port A bit 0 input only
// - Any port A pin selectable for keypad one
// - Serial unit owns port B bits 0,1
// - Timer channel one may use port B bit 7
// - Sync serial owns port C bits 7..4
// - Only port C bits 3..0 feed keypad two
// - Port D bit 0 is debug pin after reset
// - Debug function forces port D bit 0 pullup
// - Mode sampled on first edge after reset, then debug I/O
// - Port D bit 1 is reset pin
// - Timer channel zero may use port D bit 6
// - Port D seven bits; port E plain
// - Data read: pin if input, latch if output
// - Data writes always latched, driven if GPIO output
// - Direction bit picks read source under override, except port D bits 1..0 read the pin
// - Reset clears data, inputs, pullups off
`timescale 1ns/10ps
module five_port_gpio
	import gpio_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [39:0] pin_in,
	output logic [39:0] pin_out,
	output logic [39:0] pin_oe,
	output logic [39:0] pin_pullup,
	input wire logic async_serial_enable,
	input wire logic serial_transmit_pin,
	output logic serial_receive_pin,
	input wire logic sync_serial_enable,
	input wire logic [3:0] sync_serial_out_value,
	input wire logic [3:0] sync_serial_out_enable,
	output logic sync_serial_select_pin,
	output logic sync_serial_clock_pin,
	output logic sync_serial_in_pin,
	output logic sync_serial_out_pin,
	input wire logic timer_channel_one_enable,
	input wire logic timer_channel_one_oe,
	input wire logic timer_channel_one_out,
	output logic timer_channel_one_in,
	input wire logic timer_channel_zero_enable,
	input wire logic timer_channel_zero_oe,
	input wire logic timer_channel_zero_out,
	output logic timer_channel_zero_in,
	input wire logic debug_oe,
	input wire logic debug_out,
	output logic debug_in,
	output logic debug_mode_select,
	output logic debug_function_active,
	output logic reset_pin_in,
	output logic [7:0] keypad_irq_unit_one_in,
	output logic [7:0] keypad_irq_unit_two_in
);
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_t;

	// Per-port registers; index 0..4 = ports A..E
	logic [7:0] port_data_reg [PORT_COUNT];
	logic [7:0] port_direction_reg [PORT_COUNT];
	logic [7:0] port_pullup_enable_reg [PORT_COUNT];
	logic [7:0] keypad_irq_unit_one_select;
	logic [7:0] keypad_irq_unit_two_select;
	logic debug_release;
	logic seen_aw;
	logic seen_w;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	wr_state_t wr_state;
	logic [7:0] port_mask [PORT_COUNT];
	logic [7:0] port_pins [PORT_COUNT];
	logic [7:0] periph_own [PORT_COUNT];
	logic [7:0] periph_oe [PORT_COUNT];
	logic [7:0] periph_val [PORT_COUNT];
	logic [7:0] force_pullup [PORT_COUNT];
	logic wr_go;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [1:0] next_bresp;
	logic mode_caught;

	assign port_mask[0] = PORT_MASK_A;
	assign port_mask[1] = PORT_MASK_B;
	assign port_mask[2] = PORT_MASK_C;
	assign port_mask[3] = PORT_MASK_D;
	assign port_mask[4] = PORT_MASK_E;

	always_comb begin
		for (int p = 0; p < PORT_COUNT; p++) begin
			port_pins[p] = pin_in[p*8 +: 8] & port_mask[p];
			periph_own[p] = 8'h00;
			periph_oe[p] = 8'h00;
			periph_val[p] = 8'h00;
			force_pullup[p] = 8'h00;
		end
		// Serial unit: bit 0 transmit, bit 1 receive
		if (async_serial_enable) begin
			periph_own[1][1:0] = 2'b11;
			periph_oe[1][0] = 1'b1;
			periph_val[1][0] = serial_transmit_pin;
		end
		if (timer_channel_one_enable) begin
			periph_own[1][7] = 1'b1;
			periph_oe[1][7] = timer_channel_one_oe;
			periph_val[1][7] = timer_channel_one_out;
		end
		if (sync_serial_enable) begin
			periph_own[2][7:4] = 4'hF;
			periph_oe[2][7:4] = sync_serial_out_enable;
			periph_val[2][7:4] = sync_serial_out_value;
		end
		// Debug pin owned until software releases it
		if (!debug_release) begin
			periph_own[3][0] = 1'b1;
			periph_oe[3][0] = debug_oe;
			periph_val[3][0] = debug_out;
			force_pullup[3][0] = 1'b1;
		end
		periph_own[3][1] = 1'b1;
		if (timer_channel_zero_enable) begin
			periph_own[3][6] = 1'b1;
			periph_oe[3][6] = timer_channel_zero_oe;
			periph_val[3][6] = timer_channel_zero_out;
		end
	end

	// Pin drive: peripheral first, else GPIO
	always_comb begin
		for (int p = 0; p < PORT_COUNT; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (periph_own[p][b]) begin
					pin_oe[p*8+b] = periph_oe[p][b];
					pin_out[p*8+b] = periph_val[p][b];
					pin_pullup[p*8+b] = force_pullup[p][b] |
						(!periph_oe[p][b] & !port_direction_reg[p][b] &
						port_pullup_enable_reg[p][b]);
				end else begin
					pin_oe[p*8+b] = port_direction_reg[p][b];
					pin_out[p*8+b] = port_data_reg[p][b];
					pin_pullup[p*8+b] = !port_direction_reg[p][b] &
						port_pullup_enable_reg[p][b];
				end
				if (!port_mask[p][b]) begin
					pin_oe[p*8+b] = 1'b0;
					pin_out[p*8+b] = 1'b0;
					pin_pullup[p*8+b] = 1'b0;
				end
			end
		end
		pin_oe[0] = 1'b0;
		pin_out[0] = 1'b0;
	end

	assign serial_receive_pin = port_pins[1][1];
	assign timer_channel_one_in = port_pins[1][7];
	assign sync_serial_select_pin = port_pins[2][7];
	assign sync_serial_clock_pin = port_pins[2][6];
	assign sync_serial_in_pin = port_pins[2][5];
	assign sync_serial_out_pin = port_pins[2][4];
	assign timer_channel_zero_in = port_pins[3][6];
	assign debug_in = port_pins[3][0];
	assign reset_pin_in = port_pins[3][1];
	assign debug_function_active = !debug_release;
	assign keypad_irq_unit_one_in = port_pins[0] & keypad_irq_unit_one_select;
	assign keypad_irq_unit_two_in = port_pins[2] & keypad_irq_unit_two_select;

	// Mode level caught on the first edge after reset release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_caught <= 1'b0;
			debug_mode_select <= 1'b0;
		end else if (!mode_caught) begin
			mode_caught <= 1'b1;
			debug_mode_select <= port_pins[3][0];
		end
	end

	// AXI write channel capture
	assign s_axi_awready = !seen_aw && wr_state == WR_IDLE;
	assign s_axi_wready = !seen_w && wr_state == WR_IDLE;
	assign wr_go = seen_aw && seen_w && wr_state == WR_IDLE;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			seen_aw <= 1'b0;
			seen_w <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				seen_aw <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				seen_aw <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				seen_w <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				seen_w <= 1'b0;
			end
		end
	end

	always_comb begin
		next_bresp = RESP_SLVERR;
		for (int p = 0; p < PORT_COUNT; p++) begin
			if (wr_addr == PORT_STRIDE * p[11:0] + OFFSET_DATA ||
				wr_addr == PORT_STRIDE * p[11:0] + OFFSET_DIR ||
				wr_addr == PORT_STRIDE * p[11:0] + OFFSET_PULLUP) begin
				next_bresp = RESP_OKAY;
			end
		end
		if (wr_addr == OFFSET_KEYPAD_IRQ_UNIT_ONE_SEL || wr_addr == OFFSET_KEYPAD_IRQ_UNIT_TWO_SEL ||
			wr_addr == OFFSET_SYS_CTRL) begin
			next_bresp = RESP_OKAY;
		end
	end

	// Register updates on a completed write
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int p = 0; p < PORT_COUNT; p++) begin
				port_data_reg[p] <= DATA_RESET;
				port_direction_reg[p] <= DIR_RESET;
				port_pullup_enable_reg[p] <= PULLUP_RESET;
			end
			keypad_irq_unit_one_select <= 8'h00;
			keypad_irq_unit_two_select <= 8'h00;
			debug_release <= 1'b0;
		end else if (wr_go && wr_strb[0]) begin
			for (int p = 0; p < PORT_COUNT; p++) begin
				if (wr_addr == PORT_STRIDE * p[11:0] + OFFSET_DATA) begin
					port_data_reg[p] <= wr_data[7:0] & port_mask[p];
				end else if (wr_addr == PORT_STRIDE * p[11:0] + OFFSET_DIR) begin
					port_direction_reg[p] <= wr_data[7:0] & port_mask[p];
				end else if (wr_addr ==
					PORT_STRIDE * p[11:0] + OFFSET_PULLUP) begin
					port_pullup_enable_reg[p] <= wr_data[7:0] & port_mask[p];
				end
			end
			if (wr_addr == OFFSET_KEYPAD_IRQ_UNIT_ONE_SEL) begin
				keypad_irq_unit_one_select <= wr_data[7:0];
			end else if (wr_addr == OFFSET_KEYPAD_IRQ_UNIT_TWO_SEL) begin
				keypad_irq_unit_two_select <= wr_data[7:0] & KEYPAD_IRQ_UNIT_TWO_SELECT_MASK;
			end else if (wr_addr == OFFSET_SYS_CTRL) begin
				// Released debug pin returns to GPIO control
				debug_release <= wr_data[CTRL_DEBUG_RELEASE];
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_state <= WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wr_state)
				WR_IDLE: begin
					if (wr_go) begin
						wr_state <= WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= next_bresp;
					end
				end
				default: begin
					if (s_axi_bready) begin
						wr_state <= WR_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// Read decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_SLVERR;
		for (int p = 0; p < PORT_COUNT; p++) begin
			if (s_axi_araddr == PORT_STRIDE * p[11:0] + OFFSET_DATA) begin
				next_rresp = RESP_OKAY;
				// Direction bit picks the source even when overridden, except port D bits 1..0
				next_rdata[7:0] = ((port_direction_reg[p] & port_data_reg[p]) |
					(~port_direction_reg[p] & port_pins[p])) &
					port_mask[p];
				if (p == 3) begin
					next_rdata[1:0] = port_pins[3][1:0];
				end
			end else if (s_axi_araddr ==
				PORT_STRIDE * p[11:0] + OFFSET_DIR) begin
				next_rresp = RESP_OKAY;
				next_rdata[7:0] = port_direction_reg[p];
			end else if (s_axi_araddr ==
				PORT_STRIDE * p[11:0] + OFFSET_PULLUP) begin
				next_rresp = RESP_OKAY;
				next_rdata[7:0] = port_pullup_enable_reg[p];
			end
		end
		if (s_axi_araddr == OFFSET_KEYPAD_IRQ_UNIT_ONE_SEL) begin
			next_rresp = RESP_OKAY;
			next_rdata[7:0] = keypad_irq_unit_one_select;
		end else if (s_axi_araddr == OFFSET_KEYPAD_IRQ_UNIT_TWO_SEL) begin
			next_rresp = RESP_OKAY;
			next_rdata[7:0] = keypad_irq_unit_two_select;
		end else if (s_axi_araddr == OFFSET_SYS_CTRL) begin
			next_rresp = RESP_OKAY;
			next_rdata[CTRL_DEBUG_RELEASE] = debug_release;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : five_port_gpio

// >>> tb/gpio_board_model.sv
// Board model: resolves each port pin from drivers, board levels and pullups
`timescale 1ns/10ps
module gpio_board_model (
	input wire logic core_clk,
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe,
	input wire logic [39:0] pin_pullup,
	input wire logic [39:0] ext_en,
	input wire logic [39:0] ext_val,
	output logic [39:0] pin_in
);
	logic [39:0] drift = 40'h0;
	// A floating pin with no pullup wanders every cycle so it never reads as a steady level
	always @(posedge core_clk) drift <= ~drift;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup | drift));
endmodule : gpio_board_model

// >>> tb/five_port_gpio_checker.sv
// Checker: pin sharing and bus handshake properties of the GPIO block
`timescale 1ns/10ps
module five_port_gpio_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [39:0] pin_in,
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe,
	input wire logic [39:0] pin_pullup,
	input wire logic async_serial_enable,
	input wire logic serial_transmit_pin,
	input wire logic serial_receive_pin,
	input wire logic timer_channel_zero_enable,
	input wire logic timer_channel_zero_oe,
	input wire logic timer_channel_zero_out,
	input wire logic debug_function_active,
	input wire logic [7:0] keypad_irq_unit_two_in
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a0_input_a: assert property (!pin_oe[0])
		else $error("port A bit 0 driven");
	d7_absent_a: assert property ({pin_oe[31], pin_pullup[31]} == 2'b00)
		else $error("port D bit 7 active");
	reset_pin_a: assert property (!pin_oe[25])
		else $error("reset pin driven");
	pullup_input_a: assert property ((pin_oe & pin_pullup) == 40'h0)
		else $error("pullup on driven pin");
	serial_tx_a: assert property (async_serial_enable |->
		pin_oe[8] && pin_out[8] == serial_transmit_pin) else $error("tx pin");
	serial_rx_a: assert property (serial_receive_pin == pin_in[9])
		else $error("rx pin");
	timer_zero_a: assert property (timer_channel_zero_enable &&
		timer_channel_zero_oe |-> pin_oe[30] && pin_out[30] ==
		timer_channel_zero_out) else $error("timer zero pin");
	debug_pull_a: assert property (debug_function_active |-> pin_pullup[24])
		else $error("debug pullup off");
	kbi_two_a: assert property (keypad_irq_unit_two_in[7:4] == 4'h0)
		else $error("keypad two upper bits");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (async_serial_enable && timer_channel_zero_enable);
	cover property ($fell(debug_function_active));
endmodule : five_port_gpio_checker
bind five_port_gpio five_port_gpio_checker i_five_port_gpio_checker (
	.core_clk(core_clk),
	.resetn(resetn),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe(pin_oe),
	.pin_pullup(pin_pullup),
	.async_serial_enable(async_serial_enable),
	.serial_transmit_pin(serial_transmit_pin),
	.serial_receive_pin(serial_receive_pin),
	.timer_channel_zero_enable(timer_channel_zero_enable),
	.timer_channel_zero_oe(timer_channel_zero_oe),
	.timer_channel_zero_out(timer_channel_zero_out),
	.debug_function_active(debug_function_active),
	.keypad_irq_unit_two_in(keypad_irq_unit_two_in)
);

// >>> tb/five_port_gpio_tb.sv
// Testbench: registers, pin sharing and keypad selects of the GPIO block
`timescale 1ns/10ps
module five_port_gpio_tb;
	import gpio_pkg::*;
	logic core_clk, resetn, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v;
	logic r_r, ase, stx, sse, t1e, t1oe, t1o, t0e, t0oe, t0o, dfa, dms, dbg;
	logic [11:0] awa, ara;
	logic [31:0] wd, r_data;
	logic [1:0] b_resp, r_resp;
	logic [3:0] ssv, sso;
	logic [7:0] kb1, kb2, k;
	logic [39:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val, lvl, rel;
	logic [7:0] pio;
	logic [39:0] datv, dirv, puv, mall;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int err_count, samples_checked, cyc;
	assign mall = {PORT_MASK_E, PORT_MASK_D, PORT_MASK_C, PORT_MASK_B,
		PORT_MASK_A};
	five_port_gpio i_five_port_gpio (.core_clk(core_clk), .resetn(resetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
		.s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_araddr(ara), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_r), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.async_serial_enable(ase), .serial_transmit_pin(stx),
		.serial_receive_pin(), .sync_serial_enable(sse),
		.sync_serial_out_value(ssv), .sync_serial_out_enable(sso),
		.sync_serial_select_pin(pio[7]), .sync_serial_clock_pin(pio[6]),
		.sync_serial_in_pin(pio[5]), .sync_serial_out_pin(pio[4]),
		.timer_channel_one_enable(t1e), .timer_channel_one_oe(t1oe),
		.timer_channel_one_out(t1o), .timer_channel_one_in(pio[3]),
		.timer_channel_zero_enable(t0e), .timer_channel_zero_oe(t0oe),
		.timer_channel_zero_out(t0o), .timer_channel_zero_in(pio[2]),
		.debug_oe(1'b0), .debug_out(1'b0), .debug_in(pio[1]),
		.debug_mode_select(dms), .debug_function_active(dfa),
		.reset_pin_in(pio[0]), .keypad_irq_unit_one_in(kb1),
		.keypad_irq_unit_two_in(kb2));
	gpio_board_model i_gpio_board_model (.core_clk(core_clk),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.ext_en(~rel), .ext_val(ext_val), .pin_in(pin_in));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic summarize();
		$display("compared %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			summarize();
		end
		if (b_v === 1'b1 && b_r) chk(40'(b_resp), 40'(bq.pop_front()));
		if (r_v === 1'b1 && r_r) chk({r_resp, r_data}, rq.pop_front());
	end
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] r);
		logic ta, tw;
		bq.push_back(r);
		awa <= a;
		wd <= {24'h0, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		while (!(ta && tw)) begin
			@(posedge core_clk);
			if (aw_v && aw_r === 1'b1) begin
				ta = 1'b1;
				aw_v <= 1'b0;
			end
			if (w_v && w_r === 1'b1) begin
				tw = 1'b1;
				w_v <= 1'b0;
			end
		end
		do @(posedge core_clk); while (b_v !== 1'b1);
		b_r <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] r);
		rq.push_back({r, 24'h0, d});
		ara <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do @(posedge core_clk); while (ar_r !== 1'b1);
		ar_v <= 1'b0;
		do @(posedge core_clk); while (r_v !== 1'b1);
		r_r <= 1'b0;
		@(posedge core_clk);
	endtask : rd
	function automatic logic [11:0] ad(input int p, input logic [11:0] off);
		return PORT_STRIDE * 12'(p) + off;
	endfunction : ad
	function automatic logic [7:0] port_rd(input int p);
		logic [7:0] v;
		v = (dirv[p*8+:8] & datv[p*8+:8]) | (~dirv[p*8+:8] & lvl[p*8+:8]);
		if (p == 3) v[1:0] = lvl[25:24];
		return v & mall[p*8+:8];
	endfunction : port_rd
	task automatic pins(input logic [39:0] pm, po, pv);
		logic [39:0] oe, ov, pu, rl;
		oe = dirv & mall & ~pm & ~{14'h0, 1'b1, dbg, 24'h000001};
		oe = oe | (po & pm);
		ov = ((datv & ~pm) | (pv & pm)) & oe;
		pu = (puv & ~dirv & mall & ~oe) | {15'h0, dbg, 24'h0};
		// Board lets some pulled-up pins float; the pullup sets their level
		rl = pu & 40'({$urandom, $urandom});
		rel <= rl;
		@(posedge core_clk);
		chk(pin_oe, oe);
		chk(pin_out & oe, ov);
		chk(pin_pullup, pu);
		lvl = ov | (~oe & ((ext_val & ~rl) | rl));
	endtask : pins
	initial begin
		{resetn, aw_v, w_v, b_r, ar_v, r_r, cyc, err_count} = 70'h0;
		{awa, ara, wd, ssv, sso, datv, dirv, puv, samples_checked} = 216'h0;
		{ase, stx, sse, t1e, t1oe, t1o, t0e, t0oe, t0o} = 9'h000;
		dbg = 1'b1;
		rel = 40'h00_0000_0000;
		void'($urandom(32'h54F0));
		ext_val = 40'({$urandom, $urandom});
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		pins(40'h0, 40'h0, 40'h0);
		chk(dfa, 1'b1);
		chk(dms, ext_val[24]);
		for (int p = 0; p < 5; p++) begin
			rd(ad(p, OFFSET_DIR), 8'h00, RESP_OKAY);
			rd(ad(p, OFFSET_PULLUP), 8'h00, RESP_OKAY);
			rd(ad(p, OFFSET_DATA), port_rd(p), RESP_OKAY);
		end
		$display("test reset_values done");
		repeat (3) begin
			datv = 40'({$urandom, $urandom});
			dirv = 40'({$urandom, $urandom}) & ~40'h0003000001;
			puv = 40'({$urandom, $urandom});
			for (int p = 0; p < 5; p++) begin
				wr(ad(p, OFFSET_DATA), datv[p*8+:8], RESP_OKAY);
				wr(ad(p, OFFSET_DIR), dirv[p*8+:8], RESP_OKAY);
				wr(ad(p, OFFSET_PULLUP), puv[p*8+:8], RESP_OKAY);
			end
			pins(40'h0, 40'h0, 40'h0);
			for (int p = 0; p < 5; p++)
				rd(ad(p, OFFSET_DATA), port_rd(p), RESP_OKAY);
		end
		$display("test gpio_access done");
		{stx, ssv, sso, t1oe, t1o, t0oe, t0o} <= 13'($urandom);
		{ase, sse, t1e, t0e} <= 4'hF;
		@(posedge core_clk);
		pins(40'h40F08300, {9'h0, t0oe, 6'h0, sso, 4'h0, t1oe, 7'h01, 8'h0},
			{9'h0, t0o, 6'h0, ssv, 4'h0, t1o, 6'h0, stx, 8'h0});
		rd(ad(1, OFFSET_DATA), port_rd(1), RESP_OKAY);
		rd(ad(2, OFFSET_DATA), port_rd(2), RESP_OKAY);
		chk(pio, {lvl[23:20], lvl[15], lvl[30], lvl[24], lvl[25]});
		{ase, sse, t1e, t0e} <= 4'h0;
		@(posedge core_clk);
		pins(40'h0, 40'h0, 40'h0);
		$display("test peripheral_sharing done");
		for (int i = 0; i < 2; i++) begin
			k = i ? 8'($urandom) : 8'hFF;
			wr(OFFSET_KEYPAD_IRQ_UNIT_ONE_SEL, k, RESP_OKAY);
			wr(OFFSET_KEYPAD_IRQ_UNIT_TWO_SEL, k, RESP_OKAY);
			@(posedge core_clk);
			chk(kb1, lvl[7:0] & k);
			chk(kb2, lvl[23:16] & k & KEYPAD_IRQ_UNIT_TWO_SELECT_MASK);
		end
		$display("test keypad_select done");
		dirv[24] = 1'b1;
		wr(ad(3, OFFSET_DIR), dirv[31:24], RESP_OKAY);
		wr(OFFSET_SYS_CTRL, 8'h01, RESP_OKAY);
		dbg = 1'b0;
		pins(40'h0, 40'h0, 40'h0);
		chk(dfa, 1'b0);
		rd(ad(3, OFFSET_DATA), port_rd(3), RESP_OKAY);
		wr(12'hFFC, 8'h5A, RESP_SLVERR);
		rd(12'hFFC, 8'h00, RESP_SLVERR);
		$display("test debug_release done");
		summarize();
	end
endmodule : five_port_gpio_tb
